// ### logic/synth_latch_pkg.sv
// field layout, select codes and timing constants of the synthesizer programming logic
package synth_latch_pkg;
    localparam int WORD_W = 24;
    localparam int SEL_W = 2;
    localparam int SWALLOW_W = 5;
    localparam int MAIN_W = 13;
    localparam int REF_W = 14;
    localparam logic [1:0] SEL_CONTROL = 2'h0;
    localparam logic [1:0] SEL_REFERENCE = 2'h1;
    localparam logic [1:0] SEL_FEEDBACK = 2'h2;
    localparam logic [1:0] SEL_TEST = 2'h3;
    // control word fields
    localparam int CTL_CORE_LO = 2;
    localparam int CTL_CLEAR = 4;
    localparam int CTL_MUX_LO = 5;
    localparam int CTL_POL = 8;
    localparam int CTL_TRI = 9;
    localparam int CTL_GAIN = 10;
    localparam int CTL_MUTE = 11;
    localparam int CTL_PWR_LO = 12;
    localparam int CTL_CUR1_LO = 14;
    localparam int CTL_CUR2_LO = 17;
    localparam int CTL_PDARM = 20;
    localparam int CTL_PDSYNC = 21;
    localparam int CTL_PRE_LO = 22;
    // feedback word fields
    localparam int FB_SWALLOW_LO = 2;
    localparam int FB_SPARE = 7;
    localparam int FB_MAIN_LO = 8;
    localparam int FB_GAIN = 21;
    localparam int FB_HALVE = 22;
    localparam int FB_HALVE_SEL = 23;
    // reference word fields
    localparam int REF_COUNT_LO = 2;
    localparam int REF_ABL_LO = 16;
    localparam int REF_PREC = 18;
    localparam int REF_TEST = 19;
    localparam int REF_BAND_LO = 20;
    // lock detect, band select, sync power-down and reset figures
    localparam logic [2:0] LOCK_CYCLES_FINE = 3'h5;
    localparam logic [2:0] LOCK_CYCLES_COARSE = 3'h3;
    localparam logic [2:0] BAND_SELECT_CYCLES = 3'h5;
    localparam int SYNC_PD_EDGES = 2;
    localparam logic [WORD_W-1:0] WORD_RESET = 24'h000000;

    typedef struct packed {
        logic [1:0] prescaler_modulus;
        logic power_down_sync_select;
        logic power_down_arm;
        logic [5:0] pump_current_bits;
        logic [1:0] output_power_level;
        logic mute_till_lock;
        logic pump_tristate;
        logic detector_polarity;
        logic [2:0] output_mux_select;
        logic counter_clear;
        logic [1:0] core_current_level;
    } control_fields_t;

    typedef struct packed {
        logic halve_feedback_select;
        logic output_halve;
        logic [MAIN_W-1:0] main_count;
        logic [SWALLOW_W-1:0] swallow_count;
    } feedback_fields_t;

    typedef struct packed {
        logic [1:0] band_clock_divide;
        logic factory_test_enable;
        logic lock_precision;
        logic [1:0] antibacklash_width;
        logic [REF_W-1:0] ref_divide_count;
    } reference_fields_t;
endpackage

// ### logic/serial_word_shifter.sv
// 24-bit serial input register with load strobe edge detect
module serial_word_shifter #(
    parameter int WIDTH = 24
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic ser_clk_i,
    input wire logic ser_data_i,
    input wire logic load_strobe_i,
    output logic [WIDTH-1:0] word_o,
    output logic commit_o
);
    logic [1:0] clk_sync_q;
    logic [1:0] data_sync_q;
    logic [1:0] le_sync_q;
    logic clk_prev_q;
    logic le_prev_q;
    logic [WIDTH-1:0] shift_q;

    // two-stage synchronisers; only the second stage is looked at
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            clk_sync_q <= 2'h0;
            data_sync_q <= 2'h0;
            le_sync_q <= 2'h0;
            clk_prev_q <= 1'b0;
            le_prev_q <= 1'b0;
        end else if (ce_i) begin
            clk_sync_q <= {clk_sync_q[0], ser_clk_i};
            data_sync_q <= {data_sync_q[0], ser_data_i};
            le_sync_q <= {le_sync_q[0], load_strobe_i};
            clk_prev_q <= clk_sync_q[1];
            le_prev_q <= le_sync_q[1];
        end
    end

    // msb first: each rising serial clock pushes toward the top
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            shift_q <= '0;
        end else if (ce_i && clk_sync_q[1] && !clk_prev_q) begin
            shift_q <= {shift_q[WIDTH-2:0], data_sync_q[1]};
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            word_o <= '0;
            commit_o <= 1'b0;
        end else if (ce_i) begin
            commit_o <= le_sync_q[1] && !le_prev_q;
            if (le_sync_q[1] && !le_prev_q) begin
                word_o <= shift_q;
            end
        end
    end
endmodule // serial_word_shifter

// ### logic/synth_latch_programming.sv
// latch decode and power-down sequencing of the synthesizer programming logic

module synth_latch_programming (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic ser_clk_i,
    input wire logic ser_data_i,
    input wire logic load_strobe_i,
    input wire logic chip_enable_i,
    input wire logic ref_div_out_i,
    input wire logic phase_ok_i,
    output synth_latch_pkg::control_fields_t control_o,
    output synth_latch_pkg::feedback_fields_t feedback_o,
    output synth_latch_pkg::reference_fields_t reference_o,
    output logic [2:0] pump_current_o,
    output logic charge_pump_gain_o,
    output logic pump_tristate_o,
    output logic detector_polarity_o,
    output logic counters_load_o,
    output logic power_down_o,
    output logic lock_detect_o,
    output logic rf_enable_o,
    output logic band_clk_o,
    output logic band_select_busy_o,
    output logic test_latch_active_o,
    output logic [synth_latch_pkg::WORD_W-1:0] test_word_o
);
    typedef enum logic [3:0] {
        PD_RUN = 4'h1,
        PD_WAIT1 = 4'h2,
        PD_WAIT2 = 4'h4,
        PD_DOWN = 4'h8
    } pd_state_t;

    logic [synth_latch_pkg::WORD_W-1:0] word;
    logic commit;
    logic [synth_latch_pkg::WORD_W-1:0] control_word_q;
    logic [synth_latch_pkg::WORD_W-1:0] feedback_word_q;
    logic [synth_latch_pkg::WORD_W-1:0] reference_word_q;
    logic [synth_latch_pkg::WORD_W-1:0] test_word_q;
    logic gain_q;
    logic [1:0] ce_sync_q;
    logic [1:0] ref_sync_q;
    logic [1:0] ok_sync_q;
    logic ref_prev_q;
    logic ref_rise;
    pd_state_t pd_q;
    logic down;
    logic [2:0] good_cnt_q;
    logic locked_q;
    logic [2:0] band_div_q;
    logic band_prev_q;
    logic band_rise;
    logic [2:0] band_cnt_q;
    logic band_tap;
    logic fb_pending_q;
    logic fb_commit;
    logic ctl_commit;
    logic [2:0] need;

    // commit decode: the select bits sit in the lowest two positions
    function automatic logic sel_is(input logic [synth_latch_pkg::WORD_W-1:0] w, input logic [1:0] code);
        sel_is = (w[synth_latch_pkg::SEL_W-1:0] == code);
    endfunction

    serial_word_shifter #(
        .WIDTH(synth_latch_pkg::WORD_W)
    ) u_shift (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .ser_clk_i(ser_clk_i),
        .ser_data_i(ser_data_i),
        .load_strobe_i(load_strobe_i),
        .word_o(word),
        .commit_o(commit)
    );

    // pins from the analog side and the chip enable pin
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ce_sync_q <= 2'h0;
            ref_sync_q <= 2'h0;
            ok_sync_q <= 2'h0;
            ref_prev_q <= 1'b0;
        end else if (ce_i) begin
            ce_sync_q <= {ce_sync_q[0], chip_enable_i};
            ref_sync_q <= {ref_sync_q[0], ref_div_out_i};
            ok_sync_q <= {ok_sync_q[0], phase_ok_i};
            ref_prev_q <= ref_sync_q[1];
        end
    end

    assign ref_rise = ref_sync_q[1] && !ref_prev_q;

    // latches keep loading during power-down
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            control_word_q <= synth_latch_pkg::WORD_RESET;
            feedback_word_q <= synth_latch_pkg::WORD_RESET;
            reference_word_q <= synth_latch_pkg::WORD_RESET;
            test_word_q <= synth_latch_pkg::WORD_RESET;
        end else if (ce_i && commit) begin
            if (sel_is(word, synth_latch_pkg::SEL_CONTROL)) begin
                control_word_q <= word;
            end else if (sel_is(word, synth_latch_pkg::SEL_FEEDBACK)) begin
                feedback_word_q <= word;
            end else if (sel_is(word, synth_latch_pkg::SEL_REFERENCE)) begin
                reference_word_q <= word;
            end else begin
                test_word_q <= word;
            end
        end
    end

    // shared gain bit follows whichever of the control and feedback latches was written last
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            gain_q <= 1'b0;
        end else if (ce_i && commit) begin
            if (sel_is(word, synth_latch_pkg::SEL_CONTROL)) begin
                gain_q <= word[synth_latch_pkg::CTL_GAIN];
            end else if (sel_is(word, synth_latch_pkg::SEL_FEEDBACK)) begin
                gain_q <= word[synth_latch_pkg::FB_GAIN];
            end
        end
    end

    assign ctl_commit = commit && sel_is(word, synth_latch_pkg::SEL_CONTROL);

    // power-down sequencing; sync mode counts reference edges after the strobe
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pd_q <= PD_RUN;
        end else if (ce_i) begin
            // a control write with the arm bit clear cancels a pending or active power-down
            if (ctl_commit) begin
                if (!word[synth_latch_pkg::CTL_PDARM]) begin
                    pd_q <= PD_RUN;
                end else if (!word[synth_latch_pkg::CTL_PDSYNC]) begin
                    pd_q <= PD_DOWN;
                end else begin
                    pd_q <= PD_WAIT1;
                end
            end else begin
                case (pd_q)
                    PD_WAIT1: if (ref_rise) pd_q <= PD_WAIT2;
                    PD_WAIT2: if (ref_rise) pd_q <= PD_DOWN;
                    default: pd_q <= pd_q;
                endcase
            end
        end
    end

    assign down = (pd_q == PD_DOWN) || !ce_sync_q[1];

    // digital lock detect: consecutive good detector cycles
    assign need = reference_word_q[synth_latch_pkg::REF_PREC] ?
        synth_latch_pkg::LOCK_CYCLES_FINE : synth_latch_pkg::LOCK_CYCLES_COARSE;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            good_cnt_q <= 3'h0;
            locked_q <= 1'b0;
        end else if (ce_i) begin
            if (down || control_word_q[synth_latch_pkg::CTL_CLEAR]) begin
                good_cnt_q <= 3'h0;
                locked_q <= 1'b0;
            end else if (ref_rise) begin
                if (!ok_sync_q[1]) begin
                    good_cnt_q <= 3'h0;
                    locked_q <= 1'b0;
                end else if (good_cnt_q + 3'h1 >= need) begin
                    good_cnt_q <= need;
                    locked_q <= 1'b1;
                end else begin
                    good_cnt_q <= good_cnt_q + 3'h1;
                end
            end
        end
    end

    // band clock divider by 1, 2, 4 or 8 of the reference output
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            band_div_q <= 3'h0;
        end else if (ce_i && ref_rise) begin
            band_div_q <= band_div_q + 3'h1;
        end
    end

    always_comb begin
        case (reference_word_q[synth_latch_pkg::REF_BAND_LO +: 2])
            2'h0: band_tap = ref_sync_q[1];
            2'h1: band_tap = band_div_q[0];
            2'h2: band_tap = band_div_q[1];
            default: band_tap = band_div_q[2];
        endcase
    end

    assign band_rise = band_tap && !band_prev_q;

    assign fb_commit = commit && sel_is(word, synth_latch_pkg::SEL_FEEDBACK);

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            band_prev_q <= 1'b0;
        end else if (ce_i) begin
            band_prev_q <= band_tap;
        end
    end

    // a feedback write starts band select for a fixed number of band clock cycles
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            band_cnt_q <= 3'h0;
        end else if (ce_i) begin
            if (fb_commit) begin
                band_cnt_q <= synth_latch_pkg::BAND_SELECT_CYCLES;
            end else if (down) begin
                band_cnt_q <= 3'h0;
            end else if (band_rise && band_cnt_q != 3'h0) begin
                band_cnt_q <= band_cnt_q - 3'h1;
            end
        end
    end

    // bridges the cycle in which the count loads; a new write wins over the clear
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            fb_pending_q <= 1'b0;
        end else if (ce_i) begin
            if (fb_commit) begin
                fb_pending_q <= 1'b1;
            end else if (band_cnt_q == 3'h0) begin
                fb_pending_q <= 1'b0;
            end
        end
    end

    // latch images without select bits; the shared gain bit leaves through its own port
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            control_o <= '0;
            feedback_o <= '0;
            reference_o <= '0;
        end else if (ce_i) begin
            control_o <= {control_word_q[synth_latch_pkg::WORD_W-1:synth_latch_pkg::CTL_GAIN+1],
                control_word_q[synth_latch_pkg::CTL_GAIN-1:synth_latch_pkg::SEL_W]};
            feedback_o.halve_feedback_select <= feedback_word_q[synth_latch_pkg::FB_HALVE_SEL];
            feedback_o.output_halve <= feedback_word_q[synth_latch_pkg::FB_HALVE];
            feedback_o.main_count <= feedback_word_q[synth_latch_pkg::FB_MAIN_LO +: synth_latch_pkg::MAIN_W];
            feedback_o.swallow_count <=
                feedback_word_q[synth_latch_pkg::FB_SWALLOW_LO +: synth_latch_pkg::SWALLOW_W];
            reference_o <= reference_word_q[synth_latch_pkg::REF_BAND_LO+1:synth_latch_pkg::REF_COUNT_LO];
        end
    end

    // charge pump controls
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pump_current_o <= 3'h0;
            charge_pump_gain_o <= 1'b0;
            pump_tristate_o <= 1'b1;
            detector_polarity_o <= 1'b0;
        end else if (ce_i) begin
            pump_current_o <= gain_q ? control_word_q[synth_latch_pkg::CTL_CUR2_LO +: 3] :
                control_word_q[synth_latch_pkg::CTL_CUR1_LO +: 3];
            charge_pump_gain_o <= gain_q;
            pump_tristate_o <= down || control_word_q[synth_latch_pkg::CTL_TRI];
            detector_polarity_o <= control_word_q[synth_latch_pkg::CTL_POL];
        end
    end

    // power-down state as seen by the counters and the outside
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            counters_load_o <= 1'b1;
            power_down_o <= 1'b0;
        end else if (ce_i) begin
            counters_load_o <= down || control_word_q[synth_latch_pkg::CTL_CLEAR];
            power_down_o <= down;
        end
    end

    // lock report and output stage enable
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            lock_detect_o <= 1'b0;
            rf_enable_o <= 1'b0;
        end else if (ce_i) begin
            lock_detect_o <= locked_q;
            // muted outputs stay off until lock; power-down always debiases them
            rf_enable_o <= !down && (!control_word_q[synth_latch_pkg::CTL_MUTE] || locked_q);
        end
    end

    // band select clock and busy flag
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            band_clk_o <= 1'b0;
            band_select_busy_o <= 1'b0;
        end else if (ce_i) begin
            band_clk_o <= band_tap;
            band_select_busy_o <= (band_cnt_q != 3'h0) || fb_pending_q;
        end
    end

    // the test latch only takes effect when enabled; otherwise it is ignored
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            test_latch_active_o <= 1'b0;
            test_word_o <= '0;
        end else if (ce_i) begin
            test_latch_active_o <= reference_word_q[synth_latch_pkg::REF_TEST];
            test_word_o <= reference_word_q[synth_latch_pkg::REF_TEST] ? test_word_q : '0;
        end
    end
endmodule // synth_latch_programming

// ### tb/serial_host.sv
// controller model that shifts words into the three-wire programming port
module serial_host (
    input wire logic clk_sys_i,
    input wire logic start_i,
    input wire logic [23:0] word_i,
    output logic ser_clk_o,
    output logic ser_data_o,
    output logic load_strobe_o,
    output logic busy_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        ser_clk_o = 1'h0;
        ser_data_o = 1'h0;
        load_strobe_o = 1'h0;
        busy_o = 1'h0;
    end
    // four cycles a level keeps every level past the three-cycle sync window
    task automatic hold4();
        repeat (4) @(negedge clk_sys_i);
    endtask
    always @(negedge clk_sys_i) begin
        if (start_i) begin
            busy_o = 1'h1;
            for (int i = 23; i >= 0; i--) begin
                ser_data_o = word_i[i];
                hold4();
                ser_clk_o = 1'h1;
                hold4();
                ser_clk_o = 1'h0;
            end
            // serial clock rests low between frames; data no longer shows the last bit
            ser_data_o = ~ser_data_o;
            load_strobe_o = 1'h1;
            hold4();
            load_strobe_o = 1'h0;
            busy_o = 1'h0;
        end
    end
endmodule // serial_host

// ### tb/synth_latch_checker.sv
// port assertions for the synthesizer latch programming logic
module synth_latch_checker (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic chip_enable_i,
    input wire synth_latch_pkg::control_fields_t control_o,
    input wire logic [2:0] pump_current_o,
    input wire logic charge_pump_gain_o,
    input wire logic pump_tristate_o,
    input wire logic detector_polarity_o,
    input wire logic counters_load_o,
    input wire logic power_down_o,
    input wire logic lock_detect_o,
    input wire logic rf_enable_o
);
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);
    // two quiet cycles let a registered follower catch up with its source
    sequence s_quiet;
        ($stable(control_o) && $stable(charge_pump_gain_o) && $stable(power_down_o)) [*2];
    endsequence
    AST_CURRENT_SELECT: assert property (s_quiet |-> pump_current_o == (charge_pump_gain_o ?
            control_o.pump_current_bits[5:3] : control_o.pump_current_bits[2:0]))
        else $error("pump current wrong");
    AST_PUMP_TRISTATE: assert property (s_quiet |->
            pump_tristate_o == (power_down_o || control_o.pump_tristate))
        else $error("pump tristate wrong");
    AST_COUNTER_HOLD: assert property (s_quiet |->
            counters_load_o == (power_down_o || control_o.counter_clear))
        else $error("counter hold wrong");
    AST_POLARITY: assert property (s_quiet |-> detector_polarity_o == control_o.detector_polarity)
        else $error("polarity wrong");
    AST_CHIP_OFF: assert property (!chip_enable_i [*5] |-> power_down_o)
        else $error("chip enable low ignored");
    AST_ASYNC_DOWN: assert property (
            (control_o.power_down_arm && !control_o.power_down_sync_select) [*3] |-> power_down_o)
        else $error("armed power-down missing");
    AST_LOCK_RESET: assert property ((power_down_o || control_o.counter_clear) [*3] |-> !lock_detect_o)
        else $error("lock kept while down");
    AST_MUTE: assert property ((control_o.mute_till_lock && !lock_detect_o) [*2] |-> !rf_enable_o)
        else $error("outputs on before lock");
endmodule // synth_latch_checker

bind synth_latch_programming synth_latch_checker u_checker (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .chip_enable_i(chip_enable_i), .control_o(control_o), .pump_current_o(pump_current_o),
    .charge_pump_gain_o(charge_pump_gain_o), .pump_tristate_o(pump_tristate_o),
    .detector_polarity_o(detector_polarity_o), .counters_load_o(counters_load_o),
    .power_down_o(power_down_o), .lock_detect_o(lock_detect_o), .rf_enable_o(rf_enable_o));

// ### tb/testbench.sv
// self-checking bench: serial writes, latch decode, lock and power-down
`define CHK(g, e) compare(64'(g), 64'(e))
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    // core level code assumed to be the recommended one; its encoding is not known
    localparam logic [23:0] CORE = 24'h000008;
    localparam logic [23:0] EDGES [4] = '{24'hDFFF7E, 24'h000302, 24'h00FFFD, 24'h000005};
    logic clk_sys_i = 1'h0;
    logic rst_i = 1'h1;
    logic chip_enable_i = 1'h1;
    logic ref_div_out_i = 1'h0;
    logic phase_ok_i = 1'h0;
    logic start = 1'h0;
    logic [23:0] word = 24'h0;
    logic sclk, sdat, strobe, busy, gain, tri_o, pol, cload, down, lock, rf, bclk, bbusy, tact;
    synth_latch_pkg::control_fields_t ctl;
    synth_latch_pkg::feedback_fields_t fb;
    synth_latch_pkg::reference_fields_t rf_q;
    logic [2:0] cur;
    logic [23:0] tword, m_ctl, m_fb, m_ref, m_test;
    logic m_gain;
    logic [23:0] sent_q [$];
    logic [31:0] lfsr_q = 32'h7F12;
    int miscompares = 0;
    int n_compared = 0;
    int n_ref = 0;
    always #10 clk_sys_i = ~clk_sys_i;
    serial_host u_host (.clk_sys_i(clk_sys_i), .start_i(start), .word_i(word), .ser_clk_o(sclk),
        .ser_data_o(sdat), .load_strobe_o(strobe), .busy_o(busy));
    synth_latch_programming dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(1'h1), .ser_clk_i(sclk),
        .ser_data_i(sdat), .load_strobe_i(strobe), .chip_enable_i(chip_enable_i),
        .ref_div_out_i(ref_div_out_i), .phase_ok_i(phase_ok_i), .control_o(ctl), .feedback_o(fb),
        .reference_o(rf_q), .pump_current_o(cur), .charge_pump_gain_o(gain), .pump_tristate_o(tri_o),
        .detector_polarity_o(pol), .counters_load_o(cload), .power_down_o(down), .lock_detect_o(lock),
        .rf_enable_o(rf), .band_clk_o(bclk), .band_select_busy_o(bbusy), .test_latch_active_o(tact),
        .test_word_o(tword));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic compare(input logic [63:0] g, input logic [63:0] e);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic close_out();
        if (miscompares == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // one frame through the controller model, then the model takes the word
    task automatic send(input logic [23:0] w);
        int n;
        n = 0;
        word <= w;
        start <= 1'h1;
        @(negedge clk_sys_i);
        start <= 1'h0;
        @(negedge clk_sys_i);
        while (busy === 1'h1 && n < 1000) begin
            @(negedge clk_sys_i);
            n++;
        end
        if (n == 1000) miscompares++;
        repeat (8) @(negedge clk_sys_i);
        sent_q.push_back(w);
        w = sent_q.pop_front();
        case (w[1:0])
            synth_latch_pkg::SEL_CONTROL: {m_ctl, m_gain} = {w, w[10]};
            synth_latch_pkg::SEL_FEEDBACK: {m_fb, m_gain} = {w, w[21]};
            synth_latch_pkg::SEL_REFERENCE: m_ref = w;
            default: m_test = w;
        endcase
    endtask
    task automatic pulse(input logic ok);
        phase_ok_i <= ok;
        repeat (3) @(negedge clk_sys_i);
        ref_div_out_i <= 1'h1;
        n_ref++;
        repeat (5) @(negedge clk_sys_i);
        ref_div_out_i <= 1'h0;
        repeat (5) @(negedge clk_sys_i);
    endtask
    task automatic chk_all(input logic pd);
        `CHK(ctl, {m_ctl[23:11], m_ctl[9:2]});
        `CHK(fb, {m_fb[23:22], m_fb[20:8], m_fb[6:2]});
        `CHK(rf_q, m_ref[21:2]);
        `CHK(gain, m_gain);
        `CHK(cur, m_gain ? m_ctl[19:17] : m_ctl[16:14]);
        `CHK(tri_o, pd | m_ctl[9]);
        `CHK(cload, pd | m_ctl[4]);
        `CHK(pol, m_ctl[8]);
        `CHK(down, pd);
        `CHK(tword, m_ref[19] ? m_test : 24'h0);
        `CHK(tact, m_ref[19]);
    endtask
    initial begin
        logic [23:0] w;
        repeat (2) @(negedge clk_sys_i);
        rst_i <= 1'h0;
        @(negedge clk_sys_i);
        send(24'h000005);
        send(CORE);
        send(24'h000302);
        for (int i = 0; i < 12; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            w = lfsr_q[23:0];
            case (i % 3)
                0: w = {w[23:21], 1'h0, w[19:4], CORE[3:2], 2'h0};
                1: w = {w[23:10], 2'h3, 1'h0, w[6:2], 2'h2};
                default: w = {2'h0, w[21:20], 1'h0, w[18:3], 1'h1, 2'h1};
            endcase
            send(w);
            chk_all(1'h0);
        end
        for (int k = 0; k < 4; k++) begin
            send(EDGES[k]);
            chk_all(1'h0);
        end
        send(CORE | 24'h000400);
        chk_all(1'h0);
        send(24'h000302);
        chk_all(1'h0);
        send(24'hA5A5A7);
        chk_all(1'h0);
        send(24'h080005);
        chk_all(1'h0);
        `CHK(tact, 1'h1);
        send(CORE | 24'h000800);
        for (int p = 0; p < 2; p++) begin
            send(24'h000005 | (24'(p) << 18));
            repeat (p ? 4 : 2) pulse(1'h1);
            `CHK({lock, rf}, 2'h0);
            pulse(1'h1);
            `CHK({lock, rf}, 2'h3);
            pulse(1'h0);
            `CHK(lock, 1'h0);
        end
        send(24'h000005);
        send(24'h000302);
        `CHK(bbusy, 1'h1);
        repeat (4) pulse(1'h1);
        `CHK(bbusy, 1'h1);
        pulse(1'h1);
        `CHK(bbusy, 1'h0);
        send(24'h100005);
        pulse(1'h1);
        `CHK(bclk, n_ref % 2);
        pulse(1'h1);
        `CHK(bclk, n_ref % 2);
        send(CORE | 24'h100000);
        chk_all(1'h1);
        `CHK(lock, 1'h0);
        send(24'h000009);
        chk_all(1'h1);
        send(CORE);
        chk_all(1'h0);
        send(CORE | 24'h300000);
        chk_all(1'h0);
        pulse(1'h0);
        `CHK(down, 1'h0);
        pulse(1'h0);
        chk_all(1'h1);
        send(CORE);
        chip_enable_i <= 1'h0;
        repeat (6) @(negedge clk_sys_i);
        chk_all(1'h1);
        chip_enable_i <= 1'h1;
        repeat (6) @(negedge clk_sys_i);
        chk_all(1'h0);
        close_out();
    end
    // a whole run takes some 7200 cycles
    initial begin
        repeat (60000) @(posedge clk_sys_i);
        miscompares++;
        close_out();
    end
endmodule // testbench
